// ==== verilog/acsc_core.sv ====
`default_nettype none

// ****************************************************************
// Angle correction, zero offset, self-check and trim settings
// ****************************************************************

// Summary of operation
// R1: Thirty-two entries at 11.25 degree points
// R2: Interpolate between bracketing entries, add to angle
// R3: Entries are eight bits, plus/minus 11.25 degrees
// R4: Signed two's complement, unit 360/4096 degree
// R5: Entries live at register numbers 32 to 63
// R6: Correction indexed on angle before zero offset
// R7: Host clears table before measuring corrections
// R8: Self-check mode swaps in reference signal
// R9: Real signal returns as soon as mode clears
// R10: Angle step field selects 0/90/180/270 degrees
// R11: Separate X and Y trim enables
// R12: Both enables give identical reduction both axes
// R13: Trim amount unsigned 0..255, default zero
// R14: Host keeps trim amount at most 200; the core passes any amount 0..255 unchecked
// R15: Host programs trim, then table, then zero
// R16: Subtract 16-bit zero offset after correction
// R17: Top five bits pick segment, last wraps first
// R18: Corrected angle wraps modulo one full turn
module acsc_core #(
   parameter int NUM_POINTS = acsc_pkg::NUM_POINTS,
   parameter int SEG_BITS = acsc_pkg::SEG_BITS
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Register port (register numbers as documented)
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Loose configuration bits
   input wire logic self_check_mode_i,
   input wire logic [1:0] self_check_angle_step_i,
   input wire logic x_axis_trim_enable_i,
   input wire logic y_axis_trim_enable_i,
   input wire logic [7:0] bias_trim_amount_i,
   input wire logic [15:0] zero_offset_i,
   // Angle stream
   input wire acsc_pkg::acsc_sample_t raw_sample_i,
   output acsc_pkg::acsc_sample_t out_sample_o,
   // Front-end trim settings
   output acsc_pkg::acsc_trim_t trim_o
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // The table size is a parameter, but the fraction check pins it to 32 entries; the angle word is fixed by the package
   // The segment index must address the table exactly, or wrap breaks
   if (NUM_POINTS != (1 << SEG_BITS)) begin : g_bad_geom
      $error("acsc_core: NUM_POINTS must equal 2**SEG_BITS");
   end
   if (SEG_BITS + acsc_pkg::FRAC_W != acsc_pkg::ANGLE_W) begin : g_bad_frac
      $error("acsc_core: segment and fraction must fill the angle");
   end

   localparam int FW = acsc_pkg::FRAC_W;
   localparam int AW = acsc_pkg::ANGLE_W;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Shared by write, read and checks, so the decode exists only once
   // True when a register number falls in the calibration block
   function automatic logic is_corr_addr(input logic [7:0] addr);
      is_corr_addr = (addr >= acsc_pkg::CORR_FIRST_ADDR) &&
                     (addr <= acsc_pkg::CORR_LAST_ADDR);
   endfunction : is_corr_addr

   // Table slot addressed by a register number
   function automatic logic [SEG_BITS-1:0] corr_slot(input logic [7:0] addr);
      logic [7:0] off;
      off = addr - acsc_pkg::CORR_FIRST_ADDR;
      corr_slot = off[SEG_BITS-1:0];
   endfunction : corr_slot

   // ****************************************************************
   // Correction table
   // ****************************************************************
   // Entries clear to zero at reset, which means no correction, so a fresh
   // part passes the uncorrected angle through until the host loads a table
   logic [7:0] corr_q [NUM_POINTS];  // One signed entry per 11.25 deg point

   // Each entry is its own flop group; written only when its number hits
   for (genvar i = 0; i < NUM_POINTS; i++) begin : g_tab
      always_ff @(posedge clk_sys_i) begin
         if (srst_i) begin
            corr_q[i] <= acsc_pkg::CORR_RESET;
         end else if (reg_we_i && is_corr_addr(reg_addr_i) &&
                      (corr_slot(reg_addr_i) == SEG_BITS'(i))) begin
            corr_q[i] <= reg_wdata_i;  // R1 R3 R5
         end
      end
   end

   // Read answer one cycle after the strobe; off-table reads give zero
   // A read and a write to one entry in one cycle return the old value,
   // since the read samples the flops before the write lands
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         reg_rdata_o <= acsc_pkg::UNMAPPED_READ;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_re_i;
         if (reg_re_i && is_corr_addr(reg_addr_i)) begin
            reg_rdata_o <= corr_q[corr_slot(reg_addr_i)];  // R5
         end else if (reg_re_i) begin
            reg_rdata_o <= acsc_pkg::UNMAPPED_READ;
         end
      end
   end

   // ****************************************************************
   // Source select: front end or self-check reference
   // ****************************************************************
   logic [AW-1:0] ref_angle;  // Reference rotated in quarter turns
   logic [AW-1:0] src_angle;  // Uncorrected angle, zero offset not applied

   // Mode is looked at per sample, so leaving it takes effect at once.
   // Table and zero offset still act on the reference, so the self-check
   // exercises the whole processing chain, not only the source switch.
   assign ref_angle = AW'(self_check_angle_step_i) << acsc_pkg::STEP_SHIFT;  // R10
   assign src_angle = self_check_mode_i ? ref_angle : raw_sample_i.angle;  // R8 R9

   // ****************************************************************
   // Interpolation
   // ****************************************************************
   logic [SEG_BITS-1:0] seg_lo;      // Entry at or below the angle
   logic [SEG_BITS-1:0] seg_hi;      // Entry above, wrapping past the last
   logic [FW-1:0] frac;              // Position inside the segment
   logic signed [8:0] c_lo;          // Lower entry, sign extended
   logic signed [8:0] c_hi;          // Upper entry, sign extended
   logic signed [9:0] c_diff;        // Slope across the segment
   logic signed [21:0] c_prod;       // Slope times position
   logic signed [21:0] c_step;       // Scaled back by the segment length
   logic signed [9:0] c_interp;      // Interpolated correction in units
   logic [AW-1:0] corr_codes;        // Correction in angle codes
   logic [AW-1:0] corrected;         // Angle plus correction, one turn wrap
   logic [AW-1:0] final_angle;       // After zero offset

   assign seg_lo = src_angle[AW-1 -: SEG_BITS];  // R17 R6
   assign seg_hi = seg_lo + SEG_BITS'(1);        // R17
   assign frac = src_angle[FW-1:0];
   assign c_lo = signed'({corr_q[seg_lo][7], corr_q[seg_lo]});  // R4
   assign c_hi = signed'({corr_q[seg_hi][7], corr_q[seg_hi]});  // R4
   assign c_diff = 10'(c_hi) - 10'(c_lo);
   // Arithmetic shift floors toward minus; error stays under one unit.
   // One multiplier per sample keeps the answer in a single cycle; sharing
   // it over several cycles would save area but add latency to the stream.
   assign c_prod = 22'(c_diff) * signed'({11'h000, frac});
   assign c_step = c_prod >>> FW;
   // A part-select drops the sign, so it is restored before the sum
   assign c_interp = 10'(c_lo) + signed'(c_step[9:0]);  // R2
   // Sign extend then scale units to codes; range fits in 16 bits
   assign corr_codes = AW'({{6{c_interp[9]}}, c_interp} << acsc_pkg::CORR_SHIFT);
   assign corrected = src_angle + corr_codes;       // R18 R2
   assign final_angle = corrected - zero_offset_i;  // R16 R6

   // Output register: one cycle from sample to result
   // Angle holds between strobes so a slow reader still sees a whole word
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         out_sample_o <= '0;
      end else begin
         out_sample_o.valid <= raw_sample_i.valid;
         if (raw_sample_i.valid) begin
            out_sample_o.angle <= final_angle;  // R2 R16 R18
         end
      end
   end

   // ****************************************************************
   // Bias trim settings for the front end
   // ****************************************************************
   // Each axis gets the amount only when enabled; both enabled match
   // The amount passes unchecked: keeping it small enough to stay free of
   // temperature effects is left to the host, which knows the magnet
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         trim_o <= '{1'b0, 1'b0, acsc_pkg::TRIM_RESET, acsc_pkg::TRIM_RESET};
      end else begin
         trim_o.x_enable <= x_axis_trim_enable_i;  // R11
         trim_o.y_enable <= y_axis_trim_enable_i;  // R11
         trim_o.x_amount <= x_axis_trim_enable_i ? bias_trim_amount_i
                                                 : acsc_pkg::TRIM_RESET;  // R13 R12
         trim_o.y_amount <= y_axis_trim_enable_i ? bias_trim_amount_i
                                                 : acsc_pkg::TRIM_RESET;  // R13 R12
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic table_clear;  // Helper: every entry is zero

   always_comb begin
      table_clear = 1'b1;
      for (int k = 0; k < NUM_POINTS; k++) begin
         if (corr_q[k] != 8'h00) begin
            table_clear = 1'b0;
         end
      end
   end

   a_write_lands: assert property ( // R5
      @(posedge clk_sys_i) disable iff (srst_i)
      reg_we_i && is_corr_addr(reg_addr_i)
      |=> corr_q[corr_slot($past(reg_addr_i))] == $past(reg_wdata_i))
      else $error("table write did not land");

   a_read_table: assert property ( // R5
      @(posedge clk_sys_i) disable iff (srst_i)
      reg_re_i && is_corr_addr(reg_addr_i) && !reg_we_i
      |=> reg_rvalid_o && reg_rdata_o == corr_q[corr_slot($past(reg_addr_i))])
      else $error("table read wrong");

   a_read_unmapped: assert property ( // R5
      @(posedge clk_sys_i) disable iff (srst_i)
      reg_re_i && !is_corr_addr(reg_addr_i)
      |=> reg_rvalid_o && reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");

   a_clear_passes: assert property ( // R16
      @(posedge clk_sys_i) disable iff (srst_i)
      raw_sample_i.valid && table_clear && !reg_we_i
      |=> out_sample_o.valid &&
          out_sample_o.angle == 16'($past(src_angle) - $past(zero_offset_i)))
      else $error("empty table altered angle");

   a_check_ref: assert property ( // R8 R10
      @(posedge clk_sys_i) disable iff (srst_i)
      self_check_mode_i && raw_sample_i.valid && table_clear && !reg_we_i
      && zero_offset_i == 16'h0000
      |=> out_sample_o.angle == {$past(self_check_angle_step_i), 14'h0000})
      else $error("self-check angle wrong");

   a_seg_wrap: assert property ( // R17
      @(posedge clk_sys_i) disable iff (srst_i)
      src_angle[15:11] == 5'h1f |-> c_hi == signed'({corr_q[0][7], corr_q[0]}))
      else $error("last segment did not wrap");

   a_point_exact: assert property ( // R1 R2
      @(posedge clk_sys_i) disable iff (srst_i)
      raw_sample_i.valid && frac == 11'h000
      |=> out_sample_o.angle == 16'($past(src_angle) - $past(zero_offset_i)
          + 16'({{8{$past(c_lo[8])}}, $past(c_lo[7:0])} << 4)))
      else $error("correction at table point wrong");

   a_trim_both: assert property ( // R12
      @(posedge clk_sys_i) disable iff (srst_i)
      x_axis_trim_enable_i && y_axis_trim_enable_i
      |=> trim_o.x_amount == trim_o.y_amount &&
          trim_o.x_amount == $past(bias_trim_amount_i))
      else $error("both-axis trim unequal");

   a_trim_off: assert property ( // R11 R13
      @(posedge clk_sys_i) disable iff (srst_i)
      !x_axis_trim_enable_i |=> trim_o.x_amount == 8'h00 && !trim_o.x_enable)
      else $error("disabled axis still trimmed");

   a_mode_leave: assert property ( // R9
      @(posedge clk_sys_i) disable iff (srst_i)
      $fell(self_check_mode_i) |-> src_angle == raw_sample_i.angle)
      else $error("real signal not restored");

   // ****************************************************************
   // Further checks: register port, stream timing, bounds and trim
   // ****************************************************************
   // Helpers below feed the assertions only; they drive no output
   logic [NUM_POINTS*acsc_pkg::CORR_W-1:0] table_flat;  // Every entry side by side
   logic signed [9:0] c_min;  // Smaller of the two bracketing entries
   logic signed [9:0] c_max;  // Larger of the two bracketing entries

   // Flatten the table so one sampled-value call can watch every entry
   for (genvar j = 0; j < NUM_POINTS; j++) begin : g_flat
      assign table_flat[j*acsc_pkg::CORR_W +: acsc_pkg::CORR_W] = corr_q[j];
   end

   // Interpolation may never leave the interval its two entries span
   assign c_min = (c_lo <= c_hi) ? 10'(c_lo) : 10'(c_hi);
   assign c_max = (c_lo <= c_hi) ? 10'(c_hi) : 10'(c_lo);

   // An off-table write must leave every entry untouched
   a_write_ignored: assert property ( // R5
      @(posedge clk_sys_i) disable iff (srst_i)
      reg_we_i && !is_corr_addr(reg_addr_i) |=> $stable(table_flat))
      else $error("off-table write changed an entry");

   // One answer strobe per read strobe; a stray strobe would make the host
   // take data for a read it never issued
   a_rvalid_pulse: assert property ( // R5
      @(posedge clk_sys_i) disable iff (srst_i)
      1'b1 |=> reg_rvalid_o == $past(reg_re_i))
      else $error("read answer strobe wrong");

   // Read data holds between reads, so a slow host can still take it
   a_rdata_hold: assert property ( // R5
      @(posedge clk_sys_i) disable iff (srst_i)
      !reg_re_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");

   // A sign slip in the slope or the sum would push the result outside
   // the bracket, even where the table entries themselves are legal
   a_interp_bounds: assert property ( // R2
      @(posedge clk_sys_i) disable iff (srst_i)
      c_interp >= c_min && c_interp <= c_max)
      else $error("interpolation left its segment");

   // Entries span plus or minus 11.25 degrees, so the blend does too
   a_corr_range: assert property ( // R3
      @(posedge clk_sys_i) disable iff (srst_i)
      c_interp >= -10'sd128 && c_interp <= 10'sd127)
      else $error("correction out of range");

   // Self-check puts the step field in the top two bits and clears the rest,
   // giving exact quarter turns
   a_mode_enter: assert property ( // R8 R10
      @(posedge clk_sys_i) disable iff (srst_i)
      self_check_mode_i |-> src_angle[AW-1 -: 2] == self_check_angle_step_i
      && src_angle[acsc_pkg::STEP_SHIFT-1:0] == '0)
      else $error("reference angle not a quarter turn");

   // Outside self-check the front-end angle feeds the chain untouched
   a_src_real: assert property ( // R9
      @(posedge clk_sys_i) disable iff (srst_i)
      !self_check_mode_i |-> src_angle == raw_sample_i.angle)
      else $error("front-end angle not selected");

   // Output strobe trails the input strobe by exactly one cycle; downstream
   // stages count on this fixed latency
   a_valid_follow: assert property ( // R2
      @(posedge clk_sys_i) disable iff (srst_i)
      1'b1 |=> out_sample_o.valid == $past(raw_sample_i.valid))
      else $error("output strobe latency wrong");

   // Output angle holds between samples
   a_angle_hold: assert property ( // R16
      @(posedge clk_sys_i) disable iff (srst_i)
      !raw_sample_i.valid |=> $stable(out_sample_o.angle))
      else $error("output angle moved without a sample");

   // Reset leaves table, answers, output and trim at their defaults; no
   // disable here, since reset itself is what is watched
   a_reset_clear: assert property ( // R13
      @(posedge clk_sys_i)
      srst_i |=> table_clear && !reg_rvalid_o
      && out_sample_o == '0 && trim_o == '0)
      else $error("reset left state behind");

   // A disabled Y axis carries no reduction
   a_trim_y_off: assert property ( // R11 R13
      @(posedge clk_sys_i) disable iff (srst_i)
      !y_axis_trim_enable_i |=> trim_o.y_amount == acsc_pkg::TRIM_RESET && !trim_o.y_enable)
      else $error("disabled Y axis still trimmed");

   // An enabled X axis carries the amount exactly as given
   a_trim_x_on: assert property ( // R11 R13
      @(posedge clk_sys_i) disable iff (srst_i)
      x_axis_trim_enable_i |=> trim_o.x_enable && trim_o.x_amount == $past(bias_trim_amount_i))
      else $error("enabled X axis amount wrong");

   // An enabled Y axis carries the amount exactly as given
   a_trim_y_on: assert property ( // R11 R13
      @(posedge clk_sys_i) disable iff (srst_i)
      y_axis_trim_enable_i |=> trim_o.y_enable && trim_o.y_amount == $past(bias_trim_amount_i))
      else $error("enabled Y axis amount wrong");

endmodule : acsc_core

`default_nettype wire

// ==== verilog/acsc_pkg.sv ====
`default_nettype none

// ****************************************************************
// Constants and carriers for the angle correction stage
// ****************************************************************
package acsc_pkg;

   // Angle word and table geometry
   localparam int ANGLE_W = 16;        // Full turn spans 2^16 codes
   localparam int CORR_W = 8;          // Width of one correction entry
   localparam int NUM_POINTS = 32;     // Entries in the correction table
   localparam int SEG_BITS = 5;        // Angle bits that pick a segment
   localparam int FRAC_W = 11;         // Angle bits inside one segment
   // One correction unit is 360/4096 deg, i.e. 16 angle codes
   localparam int CORR_SHIFT = 4;

   // Register numbers of the calibration block
   localparam logic [7:0] CORR_FIRST_ADDR = 8'h20;
   localparam logic [7:0] CORR_LAST_ADDR = 8'h3f;
   localparam logic [7:0] CORR_RESET = 8'h00;     // Entries clear at reset
   localparam logic [7:0] UNMAPPED_READ = 8'h00;  // Answer off the table

   // Self-check reference: step of 90 deg is a shift of the 2-bit field
   localparam int STEP_SHIFT = 14;

   // Defaults of the front-end settings
   localparam logic [7:0] TRIM_RESET = 8'h00;
   localparam logic [15:0] ZERO_RESET = 16'h0000;

   // One angle sample with its strobe
   typedef struct packed {
      logic valid;
      logic [ANGLE_W-1:0] angle;
   } acsc_sample_t;

   // Per-axis bias reduction handed to the analogue front end
   typedef struct packed {
      logic x_enable;
      logic y_enable;
      logic [7:0] x_amount;
      logic [7:0] y_amount;
   } acsc_trim_t;

endpackage : acsc_pkg

`default_nettype wire

// ==== test/acsc_host_model.sv ====
`default_nettype none

// ********
// Host that programs the table over the register port
// ********
module acsc_host_model (
   // Clock
   input wire logic clk_sys_i,
   // Register port towards the device
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_we_o,
   output logic reg_re_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle port at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_we_o = 1'b0;
      reg_re_o = 1'b0;
   end

   // One write; lines scrambled after release so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_we_o = 1'b1;
      @(negedge clk_sys_i);
      reg_we_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask : wr

   // One read; answer taken one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_sys_i);
      reg_addr_o = a;
      reg_re_o = 1'b1;
      @(negedge clk_sys_i);
      reg_re_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
      v = reg_rvalid_i;
   endtask : rd

   // Clear every entry before new corrections are measured
   task automatic clear_table();
      for (int i = 0; i < 32; i++)
         wr(8'h20 + 8'(i), 8'h00);
   endtask : clear_table
endmodule : acsc_host_model

`default_nettype wire

// ==== test/acsc_core_tb.sv ====
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))

// ********
// Self-checking bench of the correction stage
// ********
module acsc_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i, srst_i, we, re, rvalid, mode, x_en, y_en;
   logic [7:0] addr, wdata, rdata, amt;
   logic [1:0] step;
   logic [15:0] zero;
   acsc_pkg::acsc_sample_t raw, outs;
   acsc_pkg::acsc_trim_t trim;
   logic [7:0] tbl [32]; // Bench copy of the table
   int mismatches, n_checks;
   logic [31:0] seed = 32'h0000_0029;

   acsc_core uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .self_check_mode_i(mode), .self_check_angle_step_i(step),
      .x_axis_trim_enable_i(x_en), .y_axis_trim_enable_i(y_en),
      .bias_trim_amount_i(amt), .zero_offset_i(zero), .raw_sample_i(raw),
      .out_sample_o(outs), .trim_o(trim));
   acsc_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
      .reg_we_o(we), .reg_re_o(re), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

   // Clock, 10 ns period
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Repeatable xorshift source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Interpolated, wrapped angle; floor division keeps negative slopes exact
   function automatic logic [15:0] exp_angle(input logic [15:0] a);
      logic [4:0] s;
      int lo, hi, c;
      s = a[15:11];
      lo = int'($signed(tbl[s]));
      hi = int'($signed(tbl[5'(s + 5'h01)]));
      c = lo + (((hi - lo) * int'(a[10:0])) >>> 11);
      return 16'(a + 16'(c * 16) - zero);
   endfunction : exp_angle

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
         mismatches++;
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   // One sample in, answer checked one cycle later
   task automatic send(input logic [15:0] a);
      logic [15:0] e;
      @(negedge clk_sys_i);
      raw = {1'b1, a};
      e = exp_angle(mode ? {step, 14'h0000} : a);
      @(negedge clk_sys_i);
      raw.valid = 1'b0;
      raw.angle = ~a;
      `CHK(outs.valid, 1'b1);
      `CHK(outs.angle, e);
   endtask : send

   task automatic put(input int i, input logic [7:0] d);
      host.wr(8'h20 + 8'(i), d);
      tbl[i] = d;
   endtask : put

   task automatic trim_chk(input logic xe, input logic ye, input logic [7:0] a);
      @(negedge clk_sys_i);
      x_en = xe;
      y_en = ye;
      amt = a;
      @(negedge clk_sys_i);
      `CHK(trim, {xe, ye, xe ? a : 8'h00, ye ? a : 8'h00});
   endtask : trim_chk

   // Hang guard
   initial begin
      repeat (50000) @(posedge clk_sys_i);
      mismatches++;
      give_verdict();
   end

   // Main sequence: trim, then table, then zero offset
   initial begin
      logic [7:0] d;
      logic v;
      srst_i = 1'b1;
      raw = '0;
      mode = 1'b0;
      step = 2'h0;
      x_en = 1'b0;
      y_en = 1'b0;
      amt = 8'h00;
      zero = 16'h0000;
      foreach (tbl[i]) tbl[i] = 8'h00;
      repeat (3) @(negedge clk_sys_i);
      srst_i = 1'b0;
      `CHK(trim, 18'h0_0000);
      for (int i = 0; i < 32; i++) begin
         host.rd(8'h20 + 8'(i), d, v);
         `CHK({v, d}, 9'h100);
      end
      // Off-table accesses are ignored and read as zero
      host.wr(8'h1f, 8'h5a);
      host.wr(8'h40, 8'ha5);
      host.rd(8'h40, d, v);
      `CHK({v, d}, 9'h100);
      host.rd(8'h20, d, v);
      `CHK(d, 8'h00);
      // Empty table: reference shows exact steps, angle passes unchanged
      mode = 1'b1;
      for (int k = 0; k < 4; k++) begin
         step = 2'(k);
         send(16'(rnd()));
      end
      mode = 1'b0;
      send(16'(rnd()));
      for (int k = 0; k < 4; k++)
         trim_chk(k[0], k[1], 8'(rnd() % 201));
      trim_chk(1'b1, 1'b1, 8'hff);
      host.clear_table();
      for (int i = 0; i < 32; i++)
         put(i, 8'(rnd()));
      put(30, 8'h7f);
      put(31, 8'h80);
      for (int i = 0; i < 32; i++) begin
         host.rd(8'h20 + 8'(i), d, v);
         `CHK(d, tbl[i]);
      end
      send(16'h0000);
      send(16'h07ff);
      send(16'hf7ff);
      send(16'hffff);
      for (int n = 0; n < 200; n++) begin
         zero = 16'(rnd());
         send(16'(rnd()));
      end
      mode = 1'b1;
      for (int k = 0; k < 4; k++) begin
         step = 2'(k);
         send(16'(rnd()));
      end
      mode = 1'b0;
      send(16'h1234);
      // Reset in mid-run clears trim and table again
      srst_i = 1'b1;
      @(negedge clk_sys_i);
      srst_i = 1'b0;
      `CHK(trim, 18'h0_0000);
      host.rd(8'h3f, d, v);
      `CHK({v, d}, 9'h100);
      give_verdict();
   end
endmodule : acsc_core_tb

`default_nettype wire
